// ===== rtl/fti_top.sv
// fifo thresholds, read-to-clear interrupt flags, axi4-lite slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module fti_top #(
  parameter int RX_DEPTH = 16,
  parameter int TX_DEPTH = 16,
  parameter int LVL_W    = 9,
  parameter int ABRT_W   = 17
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      ce,
  input  wire logic [fti_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [fti_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [fti_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  output var  logic [fti_pkg::DATA_W-1:0] s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [LVL_W-1:0]          rx_level,
  input  wire logic [LVL_W-1:0]          tx_level,
  input  wire logic                      rx_data_rd,
  input  wire logic                      rx_byte_in,
  input  wire logic                      tx_over_evt,
  input  wire logic                      rd_req_evt,
  input  wire logic                      abort_evt,
  input  wire logic [ABRT_W-1:0]         abort_src,
  input  wire logic                      restart_off,
  output var  logic                      rx_push,
  output var  logic [fti_pkg::NFLAG-1:0] raw_status,
  output var  logic [ABRT_W-1:0]         abort_cause,
  output var  logic                      irq
);

  // ************************************************************
  // constants derived from parameters
  // ************************************************************
  localparam logic [LVL_W-1:0] RX_FULL  = LVL_W'(RX_DEPTH);
  localparam logic [LVL_W-1:0] LVL_ONE  = LVL_W'(1);
  localparam logic [LVL_W-1:0] LVL_ZERO = '0;
  localparam logic [fti_pkg::THR_W:0] RX_MAX =
    (fti_pkg::THR_W+1)'(RX_DEPTH);
  localparam logic [fti_pkg::THR_W:0] TX_MAX =
    (fti_pkg::THR_W+1)'(TX_DEPTH);

  // ************************************************************
  // state
  // ************************************************************
  logic [fti_pkg::THR_W-1:0]  rx_thr_r;
  logic [fti_pkg::THR_W-1:0]  tx_thr_r;
  logic [fti_pkg::NFLAG-1:0]  en_r;
  logic [ABRT_W-1:0]          abort_r;
  logic [fti_pkg::ADDR_W-1:0] wa_r;
  logic [fti_pkg::DATA_W-1:0] wd_r;
  logic [3:0]                 ws_r;
  logic                       aw_full_r;
  logic                       w_full_r;

  // ************************************************************
  // bus handshakes
  // ************************************************************
  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic ar_hs;
  logic r_hs;
  logic do_wr;

  assign aw_hs = ce & s_axi_awvalid & s_axi_awready;
  assign w_hs  = ce & s_axi_wvalid & s_axi_wready;
  assign b_hs  = ce & s_axi_bvalid & s_axi_bready;
  assign ar_hs = ce & s_axi_arvalid & s_axi_arready;
  assign r_hs  = ce & s_axi_rvalid & s_axi_rready;
  // write lands once both halves are held and no answer is pending
  assign do_wr = ce & aw_full_r & w_full_r & ~s_axi_bvalid;

  // ************************************************************
  // write decode
  // ************************************************************
  logic wr_rx;
  logic wr_tx;
  logic wr_en;
  logic wr_clr;
  logic wr_map;
  logic wr_ro;

  assign wr_rx  = do_wr & (wa_r == fti_pkg::OFS_RX_THR) & ws_r[0];
  assign wr_tx  = do_wr & (wa_r == fti_pkg::OFS_TX_THR) & ws_r[0];
  assign wr_en  = do_wr & (wa_r == fti_pkg::OFS_ENABLE) & ws_r[0];
  assign wr_clr = do_wr & (wa_r == fti_pkg::OFS_CLR_MASK) & ws_r[0];
  // read-to-clear and status words accept writes without effect
  assign wr_ro  = (wa_r == fti_pkg::OFS_CLR_ALL) |
                  (wa_r == fti_pkg::OFS_CLR_RXU) |
                  (wa_r == fti_pkg::OFS_CLR_RXO) |
                  (wa_r == fti_pkg::OFS_CLR_TXO) |
                  (wa_r == fti_pkg::OFS_CLR_RDR) |
                  (wa_r == fti_pkg::OFS_STATUS)  |
                  (wa_r == fti_pkg::OFS_ABORT);
  assign wr_map = wr_ro |
                  (wa_r == fti_pkg::OFS_RX_THR) |
                  (wa_r == fti_pkg::OFS_TX_THR) |
                  (wa_r == fti_pkg::OFS_ENABLE) |
                  (wa_r == fti_pkg::OFS_CLR_MASK);

  // ************************************************************
  // threshold clamping
  // ************************************************************
  logic [fti_pkg::THR_W-1:0] wbyte;
  logic [fti_pkg::THR_W-1:0] rx_thr_w;
  logic [fti_pkg::THR_W-1:0] tx_thr_w;

  assign wbyte    = wd_r[fti_pkg::THR_W-1:0];
  assign rx_thr_w = ({1'b0, wbyte} > RX_MAX) ?
                    RX_MAX[fti_pkg::THR_W-1:0] : wbyte;
  assign tx_thr_w = ({1'b0, wbyte} > TX_MAX) ?
                    TX_MAX[fti_pkg::THR_W-1:0] : wbyte;

  // ************************************************************
  // read decode, clears act at the address handshake
  // ************************************************************
  logic                      rd_all;
  logic [fti_pkg::NFLAG-1:0] rd_ind;
  logic [fti_pkg::NFLAG-1:0] clr_v;

  assign rd_all = ar_hs & (s_axi_araddr == fti_pkg::OFS_CLR_ALL);
  assign rd_ind[fti_pkg::B_RXU] =
    ar_hs & (s_axi_araddr == fti_pkg::OFS_CLR_RXU);
  assign rd_ind[fti_pkg::B_RXO] =
    ar_hs & (s_axi_araddr == fti_pkg::OFS_CLR_RXO);
  assign rd_ind[fti_pkg::B_TXO] =
    ar_hs & (s_axi_araddr == fti_pkg::OFS_CLR_TXO);
  assign rd_ind[fti_pkg::B_RDR] =
    ar_hs & (s_axi_araddr == fti_pkg::OFS_CLR_RDR);
  assign rd_ind[fti_pkg::B_RXL] = 1'b0;
  assign rd_ind[fti_pkg::B_TXE] = 1'b0;

  // level flags are outside the mask, so no clear reaches them
  assign clr_v = ({fti_pkg::NFLAG{rd_all}} |
                  rd_ind |
                  ({fti_pkg::NFLAG{wr_clr}} &
                   wd_r[fti_pkg::NFLAG-1:0])) &
                 fti_pkg::EVENT_MASK;

  // ************************************************************
  // flag sources
  // ************************************************************
  logic                      rx_empty;
  logic                      rx_full;
  logic                      rx_hit;
  logic                      tx_hit;
  logic [fti_pkg::NFLAG-1:0] set_v;
  logic [fti_pkg::NFLAG-1:0] lvl_v;
  logic [fti_pkg::NFLAG-1:0] flag_v;

  assign rx_empty = (rx_level == LVL_ZERO);
  assign rx_full  = (rx_level >= RX_FULL);
  // stored value n means n+1 entries
  assign rx_hit = rx_level >=
                  (LVL_W'(rx_thr_r) + LVL_ONE);
  assign tx_hit = tx_level <= LVL_W'(tx_thr_r);

  assign set_v[fti_pkg::B_RXU] = rx_data_rd & rx_empty;
  assign set_v[fti_pkg::B_RXO] = rx_byte_in & rx_full;
  assign set_v[fti_pkg::B_RXL] = 1'b0;
  assign set_v[fti_pkg::B_TXO] = tx_over_evt;
  assign set_v[fti_pkg::B_TXE] = 1'b0;
  assign set_v[fti_pkg::B_RDR] = rd_req_evt;

  assign lvl_v = '0 |
    (fti_pkg::NFLAG'(rx_hit) << fti_pkg::B_RXL) |
    (fti_pkg::NFLAG'(tx_hit) << fti_pkg::B_TXE);

  // ************************************************************
  // flags: sticky for events, live for levels
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < fti_pkg::NFLAG; g = g + 1) begin : gen_flag
      if (fti_pkg::EVENT_MASK[g]) begin : gen_evt
        fti_sticky u_flag (
          .aclk    (aclk),
          .aresetn (aresetn),
          .ce      (ce),
          .set     (set_v[g]),
          .clr     (clr_v[g]),
          .q       (flag_v[g])
        );
      end else begin : gen_lvl
        assign flag_v[g] = lvl_v[g];
      end
    end
  endgenerate

  // ************************************************************
  // abort cause
  // ************************************************************
  logic              abort_keep;
  logic [ABRT_W-1:0] abort_nxt;

  // with bit 9 set and restart off, the whole cause survives the combined clear
  assign abort_keep = abort_r[fti_pkg::ABORT_KEEP] & restart_off;
  assign abort_nxt  = ((rd_all & ~abort_keep) ? '0 : abort_r) |
                      (abort_evt ? abort_src : '0);

  // ************************************************************
  // read data mux
  // ************************************************************
  logic [fti_pkg::DATA_W-1:0] rd_val;
  logic                       rd_map;
  logic [fti_pkg::DATA_W-1:0] rd_bit;
  logic                       a_rxu;
  logic                       a_rxo;
  logic                       a_txo;
  logic                       a_rdr;

  assign a_rxu = (s_axi_araddr == fti_pkg::OFS_CLR_RXU);
  assign a_rxo = (s_axi_araddr == fti_pkg::OFS_CLR_RXO);
  assign a_txo = (s_axi_araddr == fti_pkg::OFS_CLR_TXO);
  assign a_rdr = (s_axi_araddr == fti_pkg::OFS_CLR_RDR);

  // clear words show the flag, or irq for the combined word, as it was before this read
  assign rd_bit = fti_pkg::DATA_W'(
      a_rxu ? flag_v[fti_pkg::B_RXU] :
      a_rxo ? flag_v[fti_pkg::B_RXO] :
      a_txo ? flag_v[fti_pkg::B_TXO] :
      a_rdr ? flag_v[fti_pkg::B_RDR] : irq);

  assign rd_map = a_rxu | a_rxo | a_txo | a_rdr |
                  (s_axi_araddr == fti_pkg::OFS_CLR_ALL) |
                  (s_axi_araddr == fti_pkg::OFS_RX_THR) |
                  (s_axi_araddr == fti_pkg::OFS_TX_THR) |
                  (s_axi_araddr == fti_pkg::OFS_STATUS) |
                  (s_axi_araddr == fti_pkg::OFS_ENABLE) |
                  (s_axi_araddr == fti_pkg::OFS_CLR_MASK) |
                  (s_axi_araddr == fti_pkg::OFS_ABORT);

  // upper bits stay zero by the zero-extending casts
  assign rd_val =
    (s_axi_araddr == fti_pkg::OFS_RX_THR) ?
      fti_pkg::DATA_W'(rx_thr_r) :
    (s_axi_araddr == fti_pkg::OFS_TX_THR) ?
      fti_pkg::DATA_W'(tx_thr_r) :
    (s_axi_araddr == fti_pkg::OFS_STATUS) ?
      fti_pkg::DATA_W'(flag_v) :
    (s_axi_araddr == fti_pkg::OFS_ENABLE) ?
      fti_pkg::DATA_W'(en_r) :
    (s_axi_araddr == fti_pkg::OFS_ABORT) ?
      fti_pkg::DATA_W'(abort_r) :
    (rd_map && s_axi_araddr != fti_pkg::OFS_CLR_MASK) ?
      rd_bit : '0;

  // ************************************************************
  // write channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      wa_r          <= '0;
      wd_r          <= '0;
      ws_r          <= '0;
    end else begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        aw_full_r     <= 1'b1;
        wa_r          <= s_axi_awaddr;
      end else if (b_hs) begin
        s_axi_awready <= 1'b1;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        w_full_r     <= 1'b1;
        wd_r         <= s_axi_wdata;
        ws_r         <= s_axi_wstrb;
      end else if (b_hs) begin
        s_axi_wready <= 1'b1;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fti_pkg::RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? fti_pkg::RESP_OKAY : fti_pkg::RESP_SLV;
    end else if (b_hs) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= fti_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_map ? fti_pkg::RESP_OKAY : fti_pkg::RESP_SLV;
    end else if (r_hs) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_thr_r <= fti_pkg::THR_RESET;
      tx_thr_r <= fti_pkg::THR_RESET;
      en_r     <= fti_pkg::EN_RESET;
    end else begin
      if (wr_rx) begin
        rx_thr_r <= rx_thr_w;
      end
      if (wr_tx) begin
        tx_thr_r <= tx_thr_w;
      end
      if (wr_en) begin
        en_r <= wd_r[fti_pkg::NFLAG-1:0];
      end
    end
  end

  // ************************************************************
  // status outputs, all registered
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_r    <= '0;
      rx_push    <= 1'b0;
      raw_status <= '0;
      irq        <= 1'b0;
    end else if (ce) begin
      abort_r    <= abort_nxt;
      // a byte meeting a full buffer is not pushed
      rx_push    <= rx_byte_in & ~rx_full;
      raw_status <= flag_v;
      irq        <= |(((flag_v & ~clr_v) | set_v) & en_r);
    end
  end

  assign abort_cause = abort_r;

endmodule
`default_nettype wire

// ===== rtl/fti_pkg.sv
// constants for the fifo threshold and interrupt clear block
// Overview of operation
// - rx threshold raises bit 2 at/above level
// - rx threshold above depth stores depth
// - rx threshold offset by one entry
// - tx threshold raises bit 4 at/below level
// - tx threshold above depth stores depth
// - tx threshold encoded directly, no offset
// - combined clear read clears flags, abort cause
// - combined clear spares hardware-cleared flags
// - abort cause kept under bit 9 exception
// - underflow clear read clears bit 0
// - overflow clear read clears bit 1
// - tx overflow clear read clears bit 3
// - read request clear read clears bit 5
// - empty receive data read sets underflow
// - byte into full buffer: overflow, dropped
package fti_pkg;

  // ************************************************************
  // bus
  // ************************************************************
  localparam int         ADDR_W    = 8;
  localparam int         DATA_W    = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_RX_THR   = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_TX_THR   = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_CLR_ALL  = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_CLR_RXU  = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_CLR_RXO  = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_CLR_TXO  = 8'h4C;
  localparam logic [ADDR_W-1:0] OFS_CLR_RDR  = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h70;
  localparam logic [ADDR_W-1:0] OFS_ENABLE   = 8'h74;
  localparam logic [ADDR_W-1:0] OFS_CLR_MASK = 8'h78;
  localparam logic [ADDR_W-1:0] OFS_ABORT    = 8'h7C;

  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int         THR_W     = 8;
  localparam logic [7:0] THR_RESET = 8'h00;
  localparam int         NFLAG     = 6;
  localparam int         B_RXU     = 0;
  localparam int         B_RXO     = 1;
  localparam int         B_RXL     = 2;
  localparam int         B_TXO     = 3;
  localparam int         B_TXE     = 4;
  localparam int         B_RDR     = 5;
  // bits set by events and cleared by software
  localparam logic [NFLAG-1:0] EVENT_MASK = 6'h2B;
  localparam logic [NFLAG-1:0] EN_RESET   = 6'h00;
  localparam int               ABORT_KEEP = 9;

endpackage

// ===== rtl/fti_sticky.sv
// one sticky event flag, set wins over clear
`timescale 1ns/1ns
`default_nettype none
module fti_sticky (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clr,
  output var  logic q
);

  logic q_nxt;

  assign q_nxt = set | (q & ~clr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= 1'b0;
    end else if (ce) begin
      q <= q_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== tb/fti_top_assertions.sv
// concurrent checks on the fifo threshold and interrupt clear block
`timescale 1ns/1ns
`default_nettype none
module fti_chk #(
  parameter int RX_DEPTH = 16,
  parameter int LVL_W    = 9
) (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      ce,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic [fti_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [fti_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire logic [LVL_W-1:0]          rx_level,
  input wire logic [LVL_W-1:0]          tx_level,
  input wire logic                      rx_data_rd,
  input wire logic                      rx_byte_in,
  input wire logic                      rx_push,
  input wire logic [fti_pkg::NFLAG-1:0] raw_status
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ************************************************************
  // register bus
  // ************************************************************
  chk_b_answer: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready ##1 ce |=> s_axi_bvalid) else $error("write response missing");
  chk_b_hold: assert property (s_axi_bvalid && !(s_axi_bready && ce) |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_r_answer: assert property (ce && s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer missing");
  chk_r_hold: assert property (s_axi_rvalid && !(s_axi_rready && ce)
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  // ************************************************************
  // flags
  // ************************************************************
  chk_rx_lvl_flag: assert property (
    ce && rx_level == '0 |=> !raw_status[2]) else $error("rx level flag with empty fifo");
  chk_tx_lvl_flag: assert property (
    ce && tx_level == '0 |=> raw_status[4]) else $error("tx empty flag missing");
  chk_under_set: assert property (
    ce && rx_data_rd && rx_level == '0 ##1 ce |=> raw_status[0]) else $error("no underflow");
  chk_over_set: assert property (
    ce && rx_byte_in && rx_level >= RX_DEPTH ##1 ce |=> raw_status[1])
    else $error("no overflow flag");
  chk_over_drop: assert property (
    ce && rx_byte_in && rx_level >= RX_DEPTH |=> !rx_push) else $error("full fifo pushed");
  chk_push_ok: assert property (
    ce && rx_byte_in && rx_level < RX_DEPTH |=> rx_push) else $error("byte not pushed");
  chk_clr_under: assert property (
    ce && s_axi_arvalid && s_axi_arready && s_axi_araddr == fti_pkg::OFS_CLR_RXU
    && !(rx_data_rd && rx_level == '0) ##1 ce |=> !raw_status[0])
    else $error("underflow not cleared");
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
  cov_over: cover property (raw_status[1]);
  cov_push: cover property (rx_push);
endmodule
`default_nettype wire

// ===== tb/fti_top_tb.sv
// self-checking bench for the fifo threshold and interrupt clear block
`timescale 1ns/1ns
`default_nettype none
module fti_top_tb;
  localparam int RXD = 12;
  localparam int TXD = 10;
  logic        aclk, aresetn, ce, awv, wv, bre, arv, rre;
  logic        rxrd, rxin, txo, rdr, abe, rst_off;
  logic [7:0]  awa, ara;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [8:0]  rxl, txl;
  logic [16:0] abs;
  wire logic        awr, wr_rdy, bv, arr, rv, push, irq;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rdat;
  wire logic [5:0]  raw;
  wire logic [16:0] abc;
  int err_total, samples_checked;
  int evb[4] = '{0, 1, 3, 5};

  fti_top #(.RX_DEPTH(RXD), .TX_DEPTH(TXD)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .rx_level(rxl), .tx_level(txl), .rx_data_rd(rxrd), .rx_byte_in(rxin),
    .tx_over_evt(txo), .rd_req_evt(rdr), .abort_evt(abe), .abort_src(abs),
    .restart_off(rst_off), .rx_push(push), .raw_status(raw), .abort_cause(abc),
    .irq(irq));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    n = 0;
    awa <= a; awv <= 1'h1; wd <= d; ws <= s; wv <= 1'h1; bre <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awv && awr) awv <= 1'h0;
      if (wv && wr_rdy) wv <= 1'h0;
    end while (!(bv && bre) && n < 64);
    bre <= 1'h0;
    chk(br, er, "write response");
    @(posedge aclk);
  endtask

  // stall holds rready low for one answered cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                        input logic stall);
    int n;
    n = 0;
    ara <= a; arv <= 1'h1; rre <= !stall;
    do begin
      @(posedge aclk);
      n++;
      if (arv && arr) arv <= 1'h0;
      if (rv && !rre) rre <= 1'h1;
    end while (!(rv && rre) && n < 64);
    rre <= 1'h0;
    chk(rdat, ed, "read data");
    chk(rr, er, "read response");
    @(posedge aclk);
  endtask

  task automatic thr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [31:0] e);
    wr(a, d, s, fti_pkg::RESP_OKAY);
    rd_chk(a, e, fti_pkg::RESP_OKAY, 1'h1);
  endtask

  task automatic lvl(input logic [7:0] a, input logic [7:0] t, input logic [8:0] lv,
                     input int b, input logic e);
    wr(a, {24'h000000, t}, 4'hF, fti_pkg::RESP_OKAY);
    if (b == 2) rxl <= lv;
    else txl <= lv;
    repeat (3) @(posedge aclk);
    chk(raw[b], e, "level flag");
  endtask

  task automatic pulse(input int k);
    @(posedge aclk);
    case (k)
      0: rxrd <= 1'h1;
      1: rxin <= 1'h1;
      2: txo <= 1'h1;
      3: rdr <= 1'h1;
      default: abe <= 1'h1;
    endcase
    @(posedge aclk);
    {rxrd, rxin, txo, rdr, abe} <= 5'h00;
    @(posedge aclk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ************************************************************
  // clock, watchdog, tests
  // ************************************************************
  initial begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    {aresetn, awv, wv, bre, arv, rre, rxrd, rxin, txo, rdr, abe, rst_off} = 12'h000;
    ce = 1'h1;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h00000000;
    ws = 4'h0;
    rxl = 9'h000;
    txl = 9'h0FF;
    abs = 17'h00000;
    err_total = 0;
    samples_checked = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(raw, 32'h0, "flags after reset");
    chk(irq, 32'h0, "irq after reset");
    for (int i = 0; i < 7; i++)
      rd_chk(8'h38 + 8'(4 * i), 32'h0, fti_pkg::RESP_OKAY, 1'h0);
    $display("test reset done");
    thr(fti_pkg::OFS_RX_THR, 32'hFFFFFF05, 4'hF, 32'h05);
    thr(fti_pkg::OFS_RX_THR, 32'h000000C8, 4'hF, RXD);
    thr(fti_pkg::OFS_RX_THR, 32'h00000003, 4'hE, RXD);
    thr(fti_pkg::OFS_TX_THR, 32'h000000C8, 4'hF, TXD);
    thr(fti_pkg::OFS_TX_THR, 32'h00000009, 4'hF, 32'h09);
    wr(8'h20, 32'h1, 4'hF, fti_pkg::RESP_SLV);
    rd_chk(8'h20, 32'h0, fti_pkg::RESP_SLV, 1'h0);
    $display("test thresholds done");
    lvl(fti_pkg::OFS_RX_THR, 8'h03, 9'h003, 2, 1'h0);
    lvl(fti_pkg::OFS_RX_THR, 8'h03, 9'h004, 2, 1'h1);
    lvl(fti_pkg::OFS_RX_THR, 8'h00, 9'h001, 2, 1'h1);
    lvl(fti_pkg::OFS_RX_THR, 8'h00, 9'h000, 2, 1'h0);
    lvl(fti_pkg::OFS_TX_THR, 8'h02, 9'h002, 4, 1'h1);
    lvl(fti_pkg::OFS_TX_THR, 8'h02, 9'h003, 4, 1'h0);
    lvl(fti_pkg::OFS_TX_THR, 8'h00, 9'h000, 4, 1'h1);
    lvl(fti_pkg::OFS_TX_THR, 8'h00, 9'h001, 4, 1'h0);
    $display("test levels done");
    rxl <= 9'(RXD - 1);
    pulse(1);
    chk(push, 1'h1, "byte accepted");
    for (int k = 0; k < 4; k++) begin
      rxl <= (k == 1) ? 9'(RXD) : 9'h000;
      pulse(k);
      if (k == 1) chk(push, 1'h0, "byte dropped");
      repeat (2) @(posedge aclk);
      chk(raw[evb[k]], 1'h1, "event flag");
      wr(8'h44 + 8'(4 * k), 32'hFFFFFFFF, 4'hF, fti_pkg::RESP_OKAY);
      chk(raw[evb[k]], 1'h1, "flag after write");
      rd_chk(8'h44 + 8'(4 * k), 32'h1, fti_pkg::RESP_OKAY, 1'h0);
      repeat (2) @(posedge aclk);
      chk(raw[evb[k]], 1'h0, "flag cleared");
      rd_chk(8'h44 + 8'(4 * k), 32'h0, fti_pkg::RESP_OKAY, 1'h0);
    end
    rxl <= 9'h000;
    $display("test events done");
    thr(fti_pkg::OFS_ENABLE, 32'h3F, 4'hF, 32'h3F);
    abs <= 17'h00201;
    pulse(2);
    pulse(3);
    pulse(4);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h1, "irq raised");
    chk(abc, 17'h00201, "abort cause");
    rd_chk(fti_pkg::OFS_STATUS, 32'h28, fti_pkg::RESP_OKAY, 1'h0);
    wr(fti_pkg::OFS_ENABLE, 32'h0, 4'hF, fti_pkg::RESP_OKAY);
    chk(irq, 1'h0, "irq masked");
    wr(fti_pkg::OFS_ENABLE, 32'h3F, 4'hF, fti_pkg::RESP_OKAY);
    wr(fti_pkg::OFS_CLR_MASK, 32'h08, 4'hF, fti_pkg::RESP_OKAY);
    chk(raw, 32'h20, "mask clear");
    txl <= 9'h000;
    rd_chk(fti_pkg::OFS_CLR_ALL, 32'h1, fti_pkg::RESP_OKAY, 1'h1);
    repeat (2) @(posedge aclk);
    chk(raw, 32'h10, "combined clear");
    chk(abc, 17'h00000, "abort cleared");
    rst_off <= 1'h1;
    pulse(4);
    rd_chk(fti_pkg::OFS_CLR_ALL, 32'h1, fti_pkg::RESP_OKAY, 1'h0);
    chk(abc, 17'h00201, "abort kept");
    rst_off <= 1'h0;
    rd_chk(fti_pkg::OFS_CLR_ALL, 32'h1, fti_pkg::RESP_OKAY, 1'h0);
    chk(abc, 17'h00000, "abort cleared later");
    ce <= 1'h0;
    pulse(3);
    ce <= 1'h1;
    repeat (2) @(posedge aclk);
    chk(raw[5], 1'h0, "event while frozen");
    $display("test combined done");
    print_verdict();
  end
endmodule

bind fti_top fti_chk #(.RX_DEPTH(RX_DEPTH), .LVL_W(LVL_W)) i_chk (
  .aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .rx_level(rx_level), .tx_level(tx_level), .rx_data_rd(rx_data_rd),
  .rx_byte_in(rx_byte_in), .rx_push(rx_push), .raw_status(raw_status));
`default_nettype wire
